//--- core/pesp_event_select.sv
// Event selection and counting for codes 0FH to 17H
`timescale 1ns/1ps
module pesp_event_select
    import pesp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] event_code,
    input wire logic count_enable,
    input wire pesp_pipe_type pipe_u,
    input wire pesp_pipe_type pipe_v,
    input wire pesp_core_type core_ev,
    output logic [1:0] event_incr,
    output logic [PESP_CNT_W-1:0] event_count
);
    logic u_hit;
    logic v_hit_raw;
    logic [1:0] next_incr;
    logic [1:0] seg_incr;
    logic [1:0] core_incr;

    pesp_pipe_qual u_qual (
        .pipe(pipe_u),
        .code(event_code),
        .hit(u_hit)
    );
    pesp_pipe_qual v_qual (
        .pipe(pipe_v),
        .code(event_code),
        .hit(v_hit_raw)
    );

    wire logic is_seg = event_code == PESP_CODE_SEG_LOAD;
    wire logic is_br = event_code == PESP_CODE_BRANCH;
    wire logic is_taken_hit = event_code == PESP_CODE_TAKEN_OR_HIT;
    wire logic is_flush = event_code == PESP_CODE_FLUSH;
    wire logic is_instr = event_code == PESP_CODE_INSTR;
    wire logic is_instr_v = event_code == PESP_CODE_INSTR_V;
    wire logic any_seg = core_ev.seg_write | core_ev.far_seg_load; // R1 R2
    wire logic double_seg = core_ev.far_seg_load & core_ev.priv_change; // R3
    wire logic int_or_exc = core_ev.hw_int | core_ev.exception;
    // Interrupts and exceptions stand in place of a pipe instruction
    wire logic core_hit = (is_br | is_taken_hit | is_flush | is_instr) & int_or_exc; // R5 R8 R11

    always_comb begin
        seg_incr = 2'd0;
        if (is_seg && any_seg) begin
            seg_incr = double_seg ? 2'd2 : 2'd1; // R3
        end
        core_incr = 2'd0;
        if (is_instr_v) begin
            core_incr = {1'b0, v_hit_raw}; // R14
        end else if (is_seg) begin
            core_incr = seg_incr;
        end else if (core_hit && !(u_hit && v_hit_raw)) begin
            // Core event shares a slot; cap at two per clock
            core_incr = 2'({1'b0, u_hit} + {1'b0, v_hit_raw} + 2'd1);
        end else begin
            core_incr = 2'({1'b0, u_hit} + {1'b0, v_hit_raw}); // R10 R16
        end
        next_incr = count_enable ? core_incr : 2'd0;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_incr <= 2'd0;
        end else begin
            event_incr <= next_incr;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_count <= PESP_COUNT_RESET;
        end else begin
            event_count <= event_count + PESP_CNT_W'(event_incr); // R16
        end
    end

    // Checker view of each slot, built from the raw flags so a broken qualifier shows up
    wire logic u_done = pipe_u.retire & ~(pipe_u.string_repeat & pipe_u.repeat_iter);
    wire logic v_done = pipe_v.retire & ~(pipe_v.string_repeat & pipe_v.repeat_iter);
    wire logic is_tgt = event_code == PESP_CODE_TGT_HIT;
    // Enabled, no core event, second slot idle: the first slot alone decides
    wire logic u_alone = count_enable & ~int_or_exc & ~pipe_v.retire;

    sequence seg_double_s;
        count_enable && is_seg && double_seg;
    endsequence
    property seg_double_p;
        @(posedge core_clk) disable iff (!rst_n) seg_double_s |=> event_incr == 2'd2;
    endproperty
    seg_double_a: assert property (seg_double_p) // R3
        else $error("privilege change segment load not counted twice");

    seg_single_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
        count_enable && is_seg && any_seg && !double_seg |=> event_incr == 2'd1)
        else $error("segment load not counted once");

    reserved_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R15
        !(is_seg || is_br || is_taken_hit || is_flush || is_instr || is_instr_v
          || event_code == PESP_CODE_TGT_HIT) |=> event_incr == 2'd0)
        else $error("reserved code produced events");

    count_adds_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
        1'b1 |=> event_count == $past(event_count) + PESP_CNT_W'($past(event_incr)))
        else $error("counter did not add increment");

    vpipe_only_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
        count_enable && is_instr_v |=> event_incr == {1'b0, $past(v_done)})
        else $error("second pipe count wrong");

    repeat_once_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
        count_enable && is_instr_v && pipe_v.string_repeat && pipe_v.repeat_iter
        |=> event_incr == 2'd0)
        else $error("repeat iteration counted");

    serial_noflush_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
        count_enable && is_flush && !int_or_exc && (pipe_u.serializing || pipe_u.soft_int)
        && (pipe_v.serializing || pipe_v.soft_int || !pipe_v.retire) |=> event_incr == 2'd0)
        else $error("serializing or soft interrupt flushed count");

    dual_instr_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
        count_enable && is_instr && u_hit && v_hit_raw |=> event_incr == 2'd2)
        else $error("two retirements not counted");

    disabled_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
        !count_enable |=> event_incr == 2'd0)
        else $error("count while disabled");

    // Branch codes: pipe flags alone, then a core event alone
    branch_pair_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
        count_enable && is_br && !int_or_exc && u_done && v_done
        && pipe_u.branch && pipe_v.branch |=> event_incr == 2'd2)
        else $error("two executed branches not counted");

    branch_soft_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
        u_alone && is_br && u_done && pipe_u.soft_int |=> event_incr == 2'd1)
        else $error("software interrupt not counted as branch");

    branch_extra_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
        u_alone && is_br && u_done && !pipe_u.branch
        && (pipe_u.serializing || pipe_u.verify || pipe_u.desc_flush_load) |=> event_incr == 2'd1)
        else $error("serializing or verify not counted as branch");

    branch_int_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
        count_enable && is_br && core_ev.hw_int && !pipe_u.retire && !pipe_v.retire
        |=> event_incr == 2'd1)
        else $error("hardware interrupt not counted as branch");

    hit_retired_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
        count_enable && is_tgt && u_done && pipe_u.target_hit
        && !(v_done && pipe_v.target_hit) |=> event_incr == 2'd1)
        else $error("executed target hit not counted");

    hit_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
        count_enable && is_tgt && !u_done && !v_done |=> event_incr == 2'd0)
        else $error("target hit counted without execution");

    taken_hit_once_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
        u_alone && is_taken_hit && u_done && pipe_u.taken && pipe_u.target_hit
        |=> event_incr == 2'd1)
        else $error("taken branch with hit not counted once");

    flush_miss_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
        u_alone && is_flush && u_done && pipe_u.taken && pipe_u.target_miss
        && !pipe_u.serializing && !pipe_u.soft_int |=> event_incr == 2'd1)
        else $error("taken target miss flush not counted");

    flush_exc_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
        count_enable && is_flush && core_ev.exception && !pipe_u.retire && !pipe_v.retire
        |=> event_incr == 2'd1)
        else $error("exception flush not counted");

    instr_int_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
        count_enable && is_instr && int_or_exc && !pipe_u.retire && !pipe_v.retire
        |=> event_incr == 2'd1)
        else $error("interrupt or exception not counted as instruction");

    instr_soft_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
        u_alone && is_instr && u_done && pipe_u.soft_int |=> event_incr == 2'd1)
        else $error("software interrupt not counted as instruction");

    cap_two_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
        count_enable && is_instr && u_done && v_done && int_or_exc |=> event_incr == 2'd2)
        else $error("three events not capped at two");

    vpipe_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
        count_enable && is_instr_v && !pipe_v.retire |=> event_incr == 2'd0)
        else $error("second pipe count without second pipe retire");

    seg_none_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
        count_enable && is_seg && !core_ev.seg_write && !core_ev.far_seg_load
        |=> event_incr == 2'd0)
        else $error("segment count without segment load");

    // A repeated string reports its first pass plain and marks every later pass
    sequence rep_first_s;
        u_alone && is_instr && pipe_u.retire && pipe_u.string_repeat && !pipe_u.repeat_iter;
    endsequence
    sequence rep_again_s;
        u_alone && is_instr && pipe_u.retire && pipe_u.string_repeat && pipe_u.repeat_iter;
    endsequence
    rep_first_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
        rep_first_s |=> event_incr == 2'd1)
        else $error("first string pass not counted");

    rep_again_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
        rep_again_s |=> event_incr == 2'd0)
        else $error("later string pass counted");

    // Halt retires once; the halted clocks that follow carry no retire at all
    sequence halt_retire_s;
        u_alone && is_instr && u_done && pipe_u.halt;
    endsequence
    sequence halted_idle_s;
        u_alone && is_instr && !pipe_u.retire;
    endsequence
    halt_once_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
        halt_retire_s ##1 halted_idle_s |-> event_incr == 2'd1 ##1 event_incr == 2'd0)
        else $error("halt not counted exactly once");
endmodule : pesp_event_select

//--- core/pesp_pipe_qual.sv
// Per-pipe event qualification for one instruction slot
`timescale 1ns/1ps
module pesp_pipe_qual
    import pesp_pkg::*;
(
    input wire pesp_pipe_type pipe,
    input wire logic [7:0] code,
    output logic hit
);
    wire logic done = pipe.retire & ~(pipe.string_repeat & pipe.repeat_iter); // R12
    // R4 R5
    wire logic branch_ev = done & (pipe.branch | pipe.serializing | pipe.verify
                                   | pipe.desc_flush_load | pipe.soft_int);
    wire logic taken_ev = done & (pipe.taken | pipe.serializing | pipe.verify
                                  | pipe.desc_flush_load | pipe.soft_int);
    wire logic hit_ev = done & pipe.target_hit; // R6
    // R8 R9
    wire logic flush_ev = done & ~pipe.serializing & ~pipe.soft_int
                          & ((pipe.taken & pipe.target_miss) | pipe.mispredict
                             | pipe.desc_flush_load);
    always_comb begin
        if (code == PESP_CODE_BRANCH) begin
            hit = branch_ev;
        end else if (code == PESP_CODE_TGT_HIT) begin
            hit = hit_ev;
        end else if (code == PESP_CODE_TAKEN_OR_HIT) begin
            hit = taken_ev | hit_ev; // R7
        end else if (code == PESP_CODE_FLUSH) begin
            hit = flush_ev;
        end else if (code == PESP_CODE_INSTR || code == PESP_CODE_INSTR_V) begin
            hit = done; // R10 R13
        end else begin
            hit = 1'b0; // R15
        end
    end
endmodule : pesp_pipe_qual

//--- inc/pesp_pkg.sv
// Constants and carrier types for the performance event qualification block
// Function
// R1 - Code 0FH counts every write into any segment register, including the descriptor table and task registers.
// R2 - Segment loads come from explicit loads, far transfers and task switches, including those started by interrupts or exceptions.
// R3 - A far transfer or task switch that changes privilege level gives two segment-load increments.
// R4 - Code 12H counts executed taken and not-taken branches of every kind, never predicted ones.
// R5 - Code 12H also counts serializing, descriptor verify, some descriptor loads, hardware interrupts and trap or fault exceptions as taken branches.
// R6 - Code 13H counts branch target buffer hits only for instructions that are executed.
// R7 - Code 14H counts each instruction that is a taken branch or a target buffer hit once.
// R8 - Code 15H counts flushes from target misses on taken branches, mispredictions, exceptions, interrupts and some descriptor loads.
// R9 - Code 15H does not count serializing instructions or software interrupts.
// R10 - Code 16H counts executed instructions, up to two per clock.
// R11 - Code 16H counts each fault handler invocation and each interrupt or exception as an instruction.
// R12 - Code 16H counts a repeat-prefixed string instruction once, however many iterations.
// R13 - Code 16H counts each halt instruction once, however long the halt lasts.
// R14 - Code 17H counts like 16H but only instructions executed in the second pipe.
// R15 - A reserved or unhandled code signals no events, so the counter holds.
// R16 - Each clock the counter adds zero, one or two events, losing none when two coincide.
package pesp_pkg;
    localparam int PESP_CNT_W = 40;
    localparam logic [7:0] PESP_CODE_SEG_LOAD = 8'h0F;
    localparam logic [7:0] PESP_CODE_BRANCH = 8'h12;
    localparam logic [7:0] PESP_CODE_TGT_HIT = 8'h13;
    localparam logic [7:0] PESP_CODE_TAKEN_OR_HIT = 8'h14;
    localparam logic [7:0] PESP_CODE_FLUSH = 8'h15;
    localparam logic [7:0] PESP_CODE_INSTR = 8'h16;
    localparam logic [7:0] PESP_CODE_INSTR_V = 8'h17;
    localparam logic [7:0] PESP_CODE_RESET = 8'h00;
    localparam logic [PESP_CNT_W-1:0] PESP_COUNT_RESET = '0;

    // Per-pipe retirement report, valid in the clock the instruction completes
    typedef struct packed {
        logic retire;
        logic branch;
        logic taken;
        logic target_hit;
        logic mispredict;
        logic target_miss;
        logic serializing;
        logic verify;
        logic desc_flush_load;
        logic soft_int;
        logic string_repeat;
        logic repeat_iter;
        logic halt;
    } pesp_pipe_type;

    // Events not tied to one pipe
    typedef struct packed {
        logic seg_write;
        logic far_seg_load;
        logic priv_change;
        logic hw_int;
        logic exception;
    } pesp_core_type;
endpackage : pesp_pkg

//--- tb/pesp_event_select_tb.sv
// Self-checking bench for the performance event qualification block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module pesp_event_select_tb import pesp_pkg::*;;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] event_code = 8'h00;
    logic count_enable = 1'b0;
    pesp_pipe_type pipe_u = '0;
    pesp_pipe_type pipe_v = '0;
    pesp_core_type core_ev = '0;
    logic [1:0] event_incr;
    logic [PESP_CNT_W-1:0] event_count;
    logic [1:0] exp_incr = 2'h0;
    logic [PESP_CNT_W-1:0] exp_count = '0;
    int fail_count = 0;
    int check_count = 0;
    int seed = 32'hB9DBB069;
    int r;
    int q;
    always #12.5 core_clk = ~core_clk;
    pesp_event_select uut (.core_clk(core_clk), .rst_n(rst_n), .event_code(event_code),
        .count_enable(count_enable), .pipe_u(pipe_u), .pipe_v(pipe_v), .core_ev(core_ev),
        .event_incr(event_incr), .event_count(event_count));
    function automatic int ph(logic [7:0] c, pesp_pipe_type p);
        logic sb;
        sb = p.serializing | p.verify | p.desc_flush_load | p.soft_int;
        if (!p.retire) return 0;
        // Later passes of a repeated string are no new instruction for any code
        if (p.string_repeat & p.repeat_iter) return 0;
        case (c)
            8'h12: return int'(p.branch | sb);
            8'h13: return int'(p.target_hit);
            8'h14: return int'(p.taken | p.target_hit | sb);
            8'h15: return int'(((p.taken & p.target_miss) | p.mispredict | p.desc_flush_load)
                & !p.serializing & !p.soft_int);
            8'h16, 8'h17: return 1;
            default: return 0;
        endcase
    endfunction : ph
    function automatic logic [1:0] model(logic [7:0] c, logic en, pesp_pipe_type u,
        pesp_pipe_type v, pesp_core_type k);
        int n;
        n = ph(c, u) + ph(c, v);
        n = n + int'((c inside {8'h12, 8'h14, 8'h15, 8'h16}) && (k.hw_int | k.exception));
        if (c == 8'h17) n = ph(c, v);
        if (c == 8'h0F) n = int'(k.seg_write | k.far_seg_load) + int'(k.far_seg_load & k.priv_change);
        if (!en) n = 0;
        return (n > 2) ? 2'h2 : n[1:0];
    endfunction : model
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            exp_incr <= 2'h0;
            exp_count <= '0;
        end else begin
            exp_incr <= model(event_code, count_enable, pipe_u, pipe_v, core_ev);
            exp_count <= exp_count + exp_incr;
        end
    end
    always @(negedge core_clk) begin
        if (rst_n) begin
            `CHK(event_incr, exp_incr)
            `CHK(event_count, exp_count)
        end
    end
    // One sampled cycle, then an idle one, so no event is seen twice
    task automatic step(input logic [7:0] c, input logic en, input pesp_pipe_type u,
        input pesp_pipe_type v, input pesp_core_type k, input logic [1:0] e);
        event_code <= c;
        count_enable <= en;
        pipe_u <= u;
        pipe_v <= v;
        core_ev <= k;
        @(posedge core_clk);
        pipe_u <= '0;
        pipe_v <= '0;
        core_ev <= '0;
        @(negedge core_clk);
        `CHK(event_incr, e)
        @(posedge core_clk);
    endtask : step
    task automatic close_out();
        $display("TB: checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        #150000;
        fail_count++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        step(8'h0F, 1'b1, 13'h0000, 13'h0000, 5'h10, 2'h1);
        step(8'h0F, 1'b1, 13'h0000, 13'h0000, 5'h08, 2'h1);
        step(8'h0F, 1'b1, 13'h0000, 13'h0000, 5'h0C, 2'h2);
        step(8'h12, 1'b1, 13'h1800, 13'h1C00, 5'h00, 2'h2);
        step(8'h12, 1'b1, 13'h1040, 13'h0000, 5'h02, 2'h2);
        step(8'h13, 1'b1, 13'h1200, 13'h1000, 5'h02, 2'h1);
        step(8'h14, 1'b1, 13'h1E00, 13'h0000, 5'h00, 2'h1);
        step(8'h15, 1'b1, 13'h1480, 13'h1100, 5'h00, 2'h2);
        step(8'h15, 1'b1, 13'h1140, 13'h1488, 5'h00, 2'h0);
        step(8'h16, 1'b1, 13'h1000, 13'h1000, 5'h00, 2'h2);
        step(8'h16, 1'b1, 13'h0000, 13'h0000, 5'h01, 2'h1);
        step(8'h16, 1'b1, 13'h1004, 13'h0000, 5'h00, 2'h1);
        repeat (3) step(8'h16, 1'b1, 13'h1006, 13'h0000, 5'h00, 2'h0);
        step(8'h16, 1'b1, 13'h1001, 13'h0000, 5'h00, 2'h1);
        step(8'h16, 1'b1, 13'h0000, 13'h0000, 5'h00, 2'h0);
        step(8'h17, 1'b1, 13'h1000, 13'h1000, 5'h01, 2'h1);
        step(8'h10, 1'b1, 13'h1FFF, 13'h1000, 5'h1F, 2'h0);
        step(8'h11, 1'b1, 13'h1000, 13'h1FFF, 5'h1F, 2'h0);
        step(8'h16, 1'b0, 13'h1000, 13'h1000, 5'h03, 2'h0);
        step(8'h16, 1'b1, 13'h1000, 13'h1000, 5'h03, 2'h2);
        // Random traffic over all handled codes, checked against the model
        for (int i = 0; i < 3000; i++) begin
            r = $random(seed);
            q = $random(seed);
            event_code <= 8'h0F + 8'(r[3:0] % 4'h9);
            count_enable <= (r[7:4] != 4'h0);
            pipe_u <= r[8] ? pesp_pipe_type'({1'b1, r[20:9]}) : '0;
            pipe_v <= q[0] ? pesp_pipe_type'({1'b1, q[12:1]}) : '0;
            core_ev <= r[21] ? pesp_core_type'(r[26:22]) : '0;
            @(posedge core_clk);
        end
        rst_n <= 1'b0;
        // Idle inputs while reset is held, until the release drives the next step, so nothing is sampled while still in reset
        count_enable <= 1'b0;
        pipe_u <= '0;
        pipe_v <= '0;
        core_ev <= '0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        `CHK(event_count, PESP_COUNT_RESET)
        @(posedge core_clk);
        rst_n <= 1'b1;
        step(8'h16, 1'b1, 13'h1000, 13'h1000, 5'h00, 2'h2);
        repeat (5) @(posedge core_clk);
        close_out();
    end
endmodule : pesp_event_select_tb
